// ==== hdl/epvl_pkg.sv ====
// Package of constants and types for the exception priority and vector logic.
package epvl_pkg;
	// ==========================================================================
	// Sizes
	localparam int NUM_IRQ = 55;
	localparam int NUM_EXC = 71;
	localparam int EXC_W = 7;
	localparam int PRI_W = 3;
	localparam int RANK_W = 4;
	localparam int ADDR_W = 32;
	// ==========================================================================
	// Exception numbers
	localparam logic [EXC_W-1:0] EXC_NONE = 7'h00;
	localparam logic [EXC_W-1:0] EXC_RESET = 7'h01;
	localparam logic [EXC_W-1:0] EXC_NMI = 7'h02;
	localparam logic [EXC_W-1:0] EXC_HARD = 7'h03;
	localparam logic [EXC_W-1:0] EXC_MEMMANAGE = 7'h04;
	localparam logic [EXC_W-1:0] EXC_BUSFAULT = 7'h05;
	localparam logic [EXC_W-1:0] EXC_USAGE = 7'h06;
	localparam logic [EXC_W-1:0] EXC_SUPERVISOR_CALL = 7'h0B;
	localparam logic [EXC_W-1:0] EXC_DEBUGMON = 7'h0C;
	localparam logic [EXC_W-1:0] EXC_PEND_SERVICE = 7'h0E;
	localparam logic [EXC_W-1:0] EXC_SYSTICK = 7'h0F;
	localparam logic [EXC_W-1:0] EXC_IRQ_BASE = 7'h10;
	// Reserved peripheral lines: a set bit means the line is not implemented.
	localparam logic [NUM_IRQ-1:0] IRQ_RESERVED = 55'h7FF7_4008_03FE00;
	// ==========================================================================
	// Ranks: signed priority plus three, so reset -3 is rank 0.
	localparam logic [RANK_W-1:0] RANK_RESET = 4'h0;
	localparam logic [RANK_W-1:0] RANK_NMI = 4'h1;
	localparam logic [RANK_W-1:0] RANK_HARD = 4'h2;
	localparam logic [RANK_W-1:0] RANK_CFG_BASE = 4'h3;
	localparam logic [RANK_W-1:0] RANK_IDLE = 4'hF;
	localparam logic [PRI_W-1:0] PRI_RST = 3'h0;
	// ==========================================================================
	// Vector table
	localparam logic [ADDR_W-1:0] VTOR_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] VTOR_MIN = 32'h0000_0100;
	localparam logic [ADDR_W-1:0] VTOR_MAX = 32'h3FFF_FF00;
	localparam logic [ADDR_W-1:0] VTOR_ALIGN_MASK = 32'hFFFF_FF00;
	localparam logic [ADDR_W-1:0] SP_ENTRY_OFS = 32'h0000_0000;
	localparam int VEC_SHIFT = 2;
	// ==========================================================================
	// Core handshake state
	typedef enum logic [1:0] {
		EPVL_IDLE,
		EPVL_FETCH,
		EPVL_RUN
	} epvl_state_t;
endpackage

// ==== hdl/epvl_sel_if.sv ====
// Interface carrying the pending set and the selection result.
interface epvl_sel_if;
	logic [epvl_pkg::NUM_EXC-1:0] pend;
	logic [epvl_pkg::NUM_EXC*epvl_pkg::RANK_W-1:0] rank;
	logic found;
	logic [epvl_pkg::EXC_W-1:0] exc;
	logic [epvl_pkg::RANK_W-1:0] best;
	modport req (output pend, output rank, input found, input exc, input best);
	modport sel (input pend, input rank, output found, output exc, output best);
endinterface

// ==== hdl/epvl_select.sv ====
// Combinational picker of the most urgent pending exception.
module epvl_select (
	epvl_sel_if.sel s
);
	// ==========================================================================
	// Scan from the highest number down so the lowest number wins a tie.
	always_comb begin
		logic [epvl_pkg::RANK_W-1:0] r;
		r = '0;
		s.found = 1'b0;
		s.exc = epvl_pkg::EXC_NONE;
		s.best = epvl_pkg::RANK_IDLE;
		for (int i = epvl_pkg::NUM_EXC - 1; i >= 0; i--) begin
			r = s.rank[i*epvl_pkg::RANK_W +: epvl_pkg::RANK_W];
			if (s.pend[i] && (r <= s.best)) begin // see RULE7 see RULE11
				s.found = 1'b1;
				s.exc = epvl_pkg::EXC_W'(i);
				s.best = r;
			end
		end
	end
endmodule

// ==== hdl/epvl_top.sv ====
// Exception priority, preemption and vector address logic.
// Operation
// RULE1: Line n is exception n plus 16.
// RULE2: Entry zero is stack pointer, others handlers.
// RULE3: Software sets bit 0 of handlers.
// RULE4: Reset puts table base at zero.
// RULE5: Privileged write moves base within range.
// RULE6: Base aligned to 256 bytes.
// RULE7: Lower priority value means more urgent.
// RULE8: Reset, hard fault, NMI priorities fixed.
// RULE9: Configurable priorities reset to zero.
// RULE10: Configurable priorities range zero to seven.
// RULE11: Equal priority: lowest exception number wins.
// RULE12: Strictly more urgent pending preempts handler; the code does not preempt while four handlers are active.
// RULE13: Equal priority stays pending, no preemption.
// RULE14: NMI always enabled, priority minus two.
// RULE15: Hard fault minus one; reset highest.
// RULE16: Fetch address is base plus four times number.
module epvl_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Exception sources
	input wire logic [epvl_pkg::NUM_IRQ-1:0] i_irq,
	input wire logic i_nmi,
	input wire logic i_hard_fault,
	input wire logic [epvl_pkg::NUM_EXC-1:0] i_sys_exc_req,
	input wire logic [epvl_pkg::NUM_EXC-1:0] i_enable,
	// Configuration
	input wire logic i_pri_wr,
	input wire logic i_pri_priv,
	input wire logic [epvl_pkg::EXC_W-1:0] i_pri_exc,
	input wire logic [epvl_pkg::PRI_W-1:0] i_pri_val,
	input wire logic i_vtor_wr,
	input wire logic i_vtor_priv,
	input wire logic [epvl_pkg::ADDR_W-1:0] i_vtor_val,
	// Core handshake
	input wire logic i_fetch_ack,
	input wire logic i_handler_done,
	// Outputs to core
	output logic o_take,
	output logic [epvl_pkg::EXC_W-1:0] o_exc_num,
	output logic [epvl_pkg::ADDR_W-1:0] o_vec_addr,
	output logic [epvl_pkg::ADDR_W-1:0] o_sp_addr,
	output logic [epvl_pkg::ADDR_W-1:0] o_vector_base_offset_reg,
	output logic [epvl_pkg::EXC_W-1:0] o_active_exc,
	output logic [epvl_pkg::RANK_W-1:0] o_active_rank,
	output logic [epvl_pkg::NUM_EXC-1:0] o_pending,
	output logic o_vtor_err
);
	// ==========================================================================
	// Declarations
	logic [epvl_pkg::ADDR_W-1:0] vector_base_offset_reg_r;
	logic [epvl_pkg::PRI_W-1:0] pri_r [epvl_pkg::NUM_EXC];
	logic [epvl_pkg::NUM_EXC-1:0] pend_r;
	logic [epvl_pkg::NUM_EXC-1:0] set_req;
	logic [epvl_pkg::NUM_EXC-1:0] impl;
	// Four nesting levels; the two-bit stack index wraps, so depth four reads slot three.
	logic [epvl_pkg::EXC_W-1:0] stack_r [4];
	logic [epvl_pkg::RANK_W-1:0] srank_r [4];
	logic [2:0] depth_r;
	logic [epvl_pkg::EXC_W-1:0] sel_exc_r;
	logic [epvl_pkg::ADDR_W-1:0] vec_addr_r;
	logic vtor_err_r;
	logic [epvl_pkg::RANK_W-1:0] cur_rank;
	logic [epvl_pkg::ADDR_W-1:0] vtor_aligned;
	logic preempt;
	logic pri_ok;
	epvl_pkg::epvl_state_t state_r;
	epvl_sel_if s ();

	// ==========================================================================
	// Source mapping and ranks
	// Reserved lines and unused system slots never pend, whatever their inputs do.
	for (genvar g = 0; g < epvl_pkg::NUM_EXC; g++) begin : g_exc
		if (g >= 16) begin : g_irq
			assign impl[g] = !epvl_pkg::IRQ_RESERVED[g-16]; // see RULE1
			assign set_req[g] = i_irq[g-16] && impl[g] && i_enable[g]; // see RULE1
		end else if (g == 2) begin : g_nmi
			assign impl[g] = 1'b1;
			assign set_req[g] = i_nmi; // see RULE14
		end else if (g == 3) begin : g_hard
			assign impl[g] = 1'b1;
			assign set_req[g] = i_hard_fault;
		end else if (g == 4 || g == 5 || g == 6 || g == 11 || g == 12 || g == 14 || g == 15)
			begin : g_sys
			assign impl[g] = 1'b1;
			assign set_req[g] = i_sys_exc_req[g] && i_enable[g];
		end else begin : g_none
			assign impl[g] = 1'b0;
			assign set_req[g] = 1'b0;
		end
		if (g == 2) begin : g_rn
			assign s.rank[g*4 +: 4] = epvl_pkg::RANK_NMI; // see RULE14
		end else if (g == 3) begin : g_rh
			assign s.rank[g*4 +: 4] = epvl_pkg::RANK_HARD; // see RULE15
		end else if (g == 1) begin : g_rr
			assign s.rank[g*4 +: 4] = epvl_pkg::RANK_RESET; // see RULE15
		end else begin : g_rc
			// Fixed ranks sit below RANK_CFG_BASE so they always win.
			assign s.rank[g*4 +: 4] = epvl_pkg::RANK_CFG_BASE + {1'b0, pri_r[g]}; // see RULE10
		end
	end
	assign s.pend = pend_r;
	epvl_select u_sel (
		.s(s)
	);

	// ==========================================================================
	// Priority storage
	// Writes to fixed or unused slots are dropped quietly; software gets no error back.
	assign pri_ok = i_pri_wr && i_pri_priv && (i_pri_exc > epvl_pkg::EXC_HARD) // see RULE8
		&& (i_pri_exc < epvl_pkg::EXC_W'(epvl_pkg::NUM_EXC)) && impl[i_pri_exc];
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < epvl_pkg::NUM_EXC; i++) begin
				pri_r[i] <= epvl_pkg::PRI_RST; // see RULE9
			end
		end else if (pri_ok) begin
			pri_r[i_pri_exc] <= i_pri_val; // see RULE8 see RULE10
		end
	end

	// ==========================================================================
	// Vector table base
	// The low eight bits are dropped before the range test, so a stray offset rounds down.
	assign vtor_aligned = i_vtor_val & epvl_pkg::VTOR_ALIGN_MASK; // see RULE6
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			vector_base_offset_reg_r <= epvl_pkg::VTOR_RST; // see RULE4
			vtor_err_r <= 1'b0;
		end else if (i_vtor_wr) begin
			// Out-of-range or unprivileged writes keep the old base.
			if (i_vtor_priv && vtor_aligned >= epvl_pkg::VTOR_MIN
				&& vtor_aligned <= epvl_pkg::VTOR_MAX) begin // see RULE5
				vector_base_offset_reg_r <= vtor_aligned;
				vtor_err_r <= 1'b0;
			end else begin
				vtor_err_r <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Preemption decision
	assign cur_rank = (depth_r == 3'h0) ? epvl_pkg::RANK_IDLE : srank_r[depth_r[1:0] - 2'h1];
	// Strict compare: equal rank never preempts, whatever the number.
	// A full stack refuses entry, so deeper requests wait for a handler to finish.
	assign preempt = s.found && (s.best < cur_rank) && (depth_r < 3'h4); // see RULE12 see RULE13

	// ==========================================================================
	// Pending flags; a new request wins over the clear on entry.
	// Level requests therefore pend again at once after their own entry.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pend_r <= '0;
		end else begin
			for (int i = 0; i < epvl_pkg::NUM_EXC; i++) begin
				if (set_req[i]) begin
					pend_r[i] <= 1'b1; // see RULE13
				end else if (state_r == epvl_pkg::EPVL_FETCH && i_fetch_ack
					&& sel_exc_r == epvl_pkg::EXC_W'(i)) begin
					pend_r[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================================
	// Entry, fetch and nesting
	// A retire and a new request in one cycle: the retire goes first, entry follows.
	// There is no late arrival; a more urgent request during a fetch waits for the acknowledge.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r <= epvl_pkg::EPVL_IDLE;
			depth_r <= 3'h0;
			sel_exc_r <= epvl_pkg::EXC_NONE;
			vec_addr_r <= '0;
			for (int i = 0; i < 4; i++) begin
				stack_r[i] <= epvl_pkg::EXC_NONE;
				srank_r[i] <= epvl_pkg::RANK_IDLE;
			end
		end else begin
			case (state_r)
				epvl_pkg::EPVL_IDLE, epvl_pkg::EPVL_RUN: begin
					if (i_handler_done && depth_r != 3'h0) begin
						depth_r <= depth_r - 3'h1;
						state_r <= (depth_r == 3'h1) ? epvl_pkg::EPVL_IDLE : epvl_pkg::EPVL_RUN;
					end else if (preempt) begin
						sel_exc_r <= s.exc;
						vec_addr_r <= vector_base_offset_reg_r
							+ {23'h0, s.exc, 2'h0}; // see RULE16 see RULE2
						stack_r[depth_r[1:0]] <= s.exc;
						srank_r[depth_r[1:0]] <= s.best;
						state_r <= epvl_pkg::EPVL_FETCH;
					end
				end
				epvl_pkg::EPVL_FETCH: begin
					// The core cannot retire a handler while it fetches a vector.
					if (i_fetch_ack) begin
						depth_r <= depth_r + 3'h1;
						state_r <= epvl_pkg::EPVL_RUN;
					end
				end
				default: begin
					state_r <= epvl_pkg::EPVL_IDLE;
				end
			endcase
		end
	end

	// ==========================================================================
	// Outputs
	// The stack pointer entry is the first word of the table.
	assign o_take = (state_r == epvl_pkg::EPVL_FETCH);
	assign o_exc_num = sel_exc_r;
	assign o_vec_addr = vec_addr_r;
	assign o_sp_addr = vector_base_offset_reg_r + epvl_pkg::SP_ENTRY_OFS; // see RULE2
	assign o_vector_base_offset_reg = vector_base_offset_reg_r;
	assign o_active_exc = (depth_r == 3'h0) ? epvl_pkg::EXC_NONE : stack_r[depth_r[1:0] - 2'h1];
	assign o_active_rank = cur_rank;
	assign o_pending = pend_r;
	assign o_vtor_err = vtor_err_r;
endmodule

// ==== tb/epvl_properties.sv ====
// Concurrent checks on the ports of the exception priority and vector logic.
module epvl_properties (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Core handshake
	input wire logic i_fetch_ack,
	// Observed outputs
	input wire logic o_take,
	input wire logic [epvl_pkg::EXC_W-1:0] o_exc_num,
	input wire logic [epvl_pkg::ADDR_W-1:0] o_vec_addr,
	input wire logic [epvl_pkg::ADDR_W-1:0] o_sp_addr,
	input wire logic [epvl_pkg::ADDR_W-1:0] o_vector_base_offset_reg,
	input wire logic [epvl_pkg::EXC_W-1:0] o_active_exc,
	input wire logic [epvl_pkg::RANK_W-1:0] o_active_rank,
	input wire logic [epvl_pkg::NUM_EXC-1:0] o_pending
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Properties
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	vec_addr_a: assert property (o_take |->
		o_vec_addr == o_vector_base_offset_reg + {o_exc_num, 2'h0}) else $error("bad vector address");
	sp_entry_a: assert property (o_sp_addr == o_vector_base_offset_reg)
		else $error("bad stack entry");
	base_reset_a: assert property ($past(i_sys_rst) |-> o_vector_base_offset_reg == 32'h0)
		else $error("base not cleared");
	base_range_a: assert property (o_vector_base_offset_reg == 32'h0 ||
		(o_vector_base_offset_reg >= epvl_pkg::VTOR_MIN && o_vector_base_offset_reg <=
		epvl_pkg::VTOR_MAX && o_vector_base_offset_reg[7:0] == 8'h0)) else $error("bad base");
	take_hold_a: assert property (o_take && !i_fetch_ack |=> o_take && $stable(o_vec_addr))
		else $error("fetch dropped");
	ack_active_a: assert property (o_take && i_fetch_ack |=>
		!o_take && o_active_exc == $past(o_exc_num)) else $error("bad activation");
	take_pend_a: assert property (o_take |-> o_pending[o_exc_num])
		else $error("fetch without pending");
	reserved_a: assert property ((o_pending[70:16] & epvl_pkg::IRQ_RESERVED) == 55'h0)
		else $error("reserved line pending");
	nmi_top_a: assert property (o_active_rank <= epvl_pkg::RANK_NMI |-> !o_take)
		else $error("nmi preempted");
	hard_rank_a: assert property (o_active_exc == epvl_pkg::EXC_HARD |->
		o_active_rank == epvl_pkg::RANK_HARD) else $error("hard fault rank");
	cfg_rank_a: assert property (o_active_exc > epvl_pkg::EXC_HARD |->
		o_active_rank <= epvl_pkg::RANK_CFG_BASE + 4'h7) else $error("rank out of range");
endmodule

// ==== tb/epvl_core_model.sv ====
// Behavioural core that accepts vector fetches and retires handlers.
module epvl_core_model #(
	parameter int ACK_DLY = 2
) (
	// Clock
	input wire logic i_clk,
	// From the block and the bench
	input wire logic i_take,
	input wire logic i_done_req,
	input wire logic [31:0] i_vec_addr,
	// To the block and the bench
	output logic o_fetch_ack,
	output logic o_handler_done,
	output logic [31:0] o_handler_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// A slow acknowledge gives late requests time to pile up during a fetch.
	initial o_fetch_ack = 1'b0;
	always @(negedge i_clk) begin
		o_fetch_ack <= (i_take === 1'b1) && (cnt >= ACK_DLY);
		cnt <= (i_take === 1'b1) ? cnt + 1 : 0;
		// The modelled table holds an odd handler word at each entry, marking compact code.
		if (i_take === 1'b1 && cnt >= ACK_DLY) begin
			o_handler_addr <= i_vec_addr | 32'h0000_0001;
		end
	end
	assign o_handler_done = i_done_req;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the exception priority and vector logic.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_sys_rst = 1, i_nmi = 0, i_hard_fault = 0, done_req = 0;
	logic i_pri_wr = 0, i_pri_priv = 0, i_vtor_wr = 0, i_vtor_priv = 0;
	logic i_fetch_ack, i_handler_done, o_take, o_vtor_err;
	logic [54:0] i_irq = '0;
	logic [70:0] i_enable = '1, o_pending;
	logic [6:0] i_pri_exc = '0, o_exc_num, o_active_exc;
	logic [2:0] i_pri_val = '0;
	logic [3:0] o_active_rank;
	logic [31:0] i_vtor_val = '0, o_vec_addr, o_sp_addr, o_vector_base_offset_reg;
	logic [31:0] handler_addr;
	logic [70:0] sys_exc_req = '0;
	int n_mismatch = 0, num_checks = 0;
	always #10 i_clk = ~i_clk;
	epvl_top epvl_top_inst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq(i_irq), .i_nmi(i_nmi),
		.i_hard_fault(i_hard_fault), .i_sys_exc_req(sys_exc_req), .i_enable(i_enable),
		.i_pri_wr(i_pri_wr), .i_pri_priv(i_pri_priv), .i_pri_exc(i_pri_exc),
		.i_pri_val(i_pri_val), .i_vtor_wr(i_vtor_wr), .i_vtor_priv(i_vtor_priv),
		.i_vtor_val(i_vtor_val), .i_fetch_ack(i_fetch_ack), .i_handler_done(i_handler_done),
		.o_take(o_take), .o_exc_num(o_exc_num), .o_vec_addr(o_vec_addr),
		.o_sp_addr(o_sp_addr), .o_vector_base_offset_reg(o_vector_base_offset_reg),
		.o_active_exc(o_active_exc), .o_active_rank(o_active_rank),
		.o_pending(o_pending), .o_vtor_err(o_vtor_err));
	epvl_core_model epvl_core_model_inst (.i_clk(i_clk), .i_take(o_take), .i_done_req(done_req),
		.i_vec_addr(o_vec_addr), .o_fetch_ack(i_fetch_ack), .o_handler_done(i_handler_done),
		.o_handler_addr(handler_addr));
	// ==========================================================================
	// Helpers
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic fetch(input logic [6:0] e, input logic [31:0] a);
		int i = 0;
		while (o_take !== 1'b1 && i < 20) begin
			@(negedge i_clk);
			i++;
		end
		chk(o_exc_num === e && o_vec_addr === a, "vector fetch");
		while (o_take === 1'b1 && i < 40) begin
			@(negedge i_clk);
			i++;
		end
		chk(o_active_exc === e && handler_addr === (a | 32'h1), "active exception");
	endtask
	task automatic pulse(input logic [54:0] m, input logic n, input logic h);
		@(negedge i_clk);
		{i_irq, i_nmi, i_hard_fault} = {m, n, h};
		@(negedge i_clk);
		{i_irq, i_nmi, i_hard_fault} = '0;
	endtask
	task automatic nofetch();
		repeat (6) begin
			@(negedge i_clk);
			chk(o_take === 1'b0, "unexpected fetch");
		end
	endtask
	task automatic done();
		@(negedge i_clk);
		done_req = 1;
		@(negedge i_clk);
		done_req = 0;
	endtask
	task automatic pw(input logic [6:0] e, input logic [2:0] v);
		@(negedge i_clk);
		{i_pri_exc, i_pri_val, i_pri_priv, i_pri_wr} = {e, v, 2'h3};
		@(negedge i_clk);
		i_pri_wr = 0;
	endtask
	task automatic vw(input logic [31:0] v, input logic p, input logic er, input logic [31:0] b);
		@(negedge i_clk);
		{i_vtor_val, i_vtor_priv, i_vtor_wr} = {v, p, 1'b1};
		@(negedge i_clk);
		i_vtor_wr = 0;
		@(negedge i_clk);
		chk(o_vtor_err === er && o_vector_base_offset_reg === b && o_sp_addr === b, "table base");
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ==========================================================================
	// Scenarios
	task automatic s_map();
		chk(o_vector_base_offset_reg === 32'h0 && o_pending === 71'h0, "reset state");
		pulse(55'h0800_0201, 0, 0);
		fetch(7'h10, 32'h0000_0040);
		chk(o_pending[25] === 1'b0 && o_pending[43] === 1'b0, "reserved line");
		done();
		chk(o_active_exc === 7'h00 && o_active_rank === 4'hF, "return to thread");
	endtask
	task automatic s_tie();
		pulse(55'h3, 0, 0);
		fetch(7'h10, 32'h0000_0040);
		nofetch();
		chk(o_pending[17] === 1'b1, "equal stays pending");
		done();
		fetch(7'h11, 32'h0000_0044);
		done();
	endtask
	task automatic s_preempt();
		pw(7'h03, 3'h7);
		pw(7'h11, 3'h5);
		pulse(55'h2, 0, 0);
		fetch(7'h11, 32'h0000_0044);
		pulse(55'h1, 0, 0);
		fetch(7'h10, 32'h0000_0040);
		pulse(55'h0, 1, 0);
		fetch(7'h02, 32'h0000_0008);
		pulse(55'h0, 0, 1);
		nofetch();
		done();
		fetch(7'h03, 32'h0000_000C);
		repeat (3) done();
	endtask
	task automatic s_vtor();
		vw(32'h2000_0000, 1, 0, 32'h2000_0000);
		vw(32'h1000_0000, 0, 1, 32'h2000_0000);
		vw(32'h0000_0080, 1, 1, 32'h2000_0000);
		vw(32'h4000_0000, 1, 1, 32'h2000_0000);
		vw(32'h3FFF_FF7F, 1, 0, 32'h3FFF_FF00);
		pulse(55'h4, 0, 0);
		fetch(7'h12, 32'h3FFF_FF48);
		done();
		@(negedge i_clk);
		i_sys_rst = 1;
		repeat (2) @(negedge i_clk);
		i_sys_rst = 0;
		@(negedge i_clk);
		chk(o_vector_base_offset_reg === 32'h0 && o_vtor_err === 1'b0, "base after reset");
		pulse(55'h2, 0, 0);
		fetch(7'h11, 32'h0000_0044);
		pulse(55'h1, 0, 0);
		nofetch();
		done();
		fetch(7'h10, 32'h0000_0040);
		done();
	endtask
	task automatic s_gate();
		@(negedge i_clk);
		i_enable = '0;
		pulse(55'h1, 1, 0);
		fetch(7'h02, 32'h0000_0008);
		chk(o_pending[16] === 1'b0, "disabled line pending");
		done();
		@(negedge i_clk);
		i_enable = '1;
		sys_exc_req = 71'h880;
		@(negedge i_clk);
		sys_exc_req = '0;
		fetch(7'h0B, 32'h0000_002C);
		chk(o_pending[7] === 1'b0, "reserved slot pending");
		done();
	endtask
	// ==========================================================================
	// Sequence
	initial begin
		repeat (12) @(negedge i_clk);
		i_sys_rst = 0;
		@(negedge i_clk);
		s_map();
		s_tie();
		s_preempt();
		s_vtor();
		s_gate();
		summarize();
	end
	// The whole run needs under two hundred cycles; this limit is far beyond it.
	initial begin
		#200us;
		n_mismatch++;
		summarize();
	end
endmodule
bind epvl_top epvl_properties epvl_properties_inst (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fetch_ack(i_fetch_ack), .o_take(o_take),
	.o_exc_num(o_exc_num), .o_vec_addr(o_vec_addr), .o_sp_addr(o_sp_addr),
	.o_vector_base_offset_reg(o_vector_base_offset_reg), .o_active_exc(o_active_exc),
	.o_active_rank(o_active_rank), .o_pending(o_pending));
